// file: hdl/pstr_event_flags.sv
`timescale 1ns/10ps
`default_nettype none
`include "pstr_regs.svh"

module pstr_event_flags (
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    input  wire logic                 ce,
    input  wire logic [`PSTR_NEV-1:0] set_ev,
    input  wire logic [`PSTR_NEV-1:0] clr_ev,
    input  wire logic                 mask_wr,
    input  wire logic [`PSTR_NEV-1:0] mask_wdata,
    output logic      [`PSTR_NEV-1:0] status,
    output logic      [`PSTR_NEV-1:0] mask,
    output logic                      irq
);

    pstr_pkg::pstr_flag_st_t st_ff;
    pstr_pkg::pstr_flag_st_t nxt_st;

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    // A set in the cycle of its clear survives, so no event is lost
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.status = set_ev | (st_ff.status & ~clr_ev);
        if (mask_wr) begin
            nxt_st.mask = mask_wdata;
        end
        nxt_st.irq    = |(nxt_st.status & nxt_st.mask);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{status: `PSTR_EV_RST, mask: `PSTR_EV_RST, irq: 1'b0};
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign status = st_ff.status;
    assign mask   = st_ff.mask;
    assign irq    = st_ff.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_flag_sticky_set: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && set_ev[`PSTR_EV_SAMPLE] |=> status[`PSTR_EV_SAMPLE] ##1
        (status[`PSTR_EV_SAMPLE] || $past(clr_ev[`PSTR_EV_SAMPLE]) || !$past(ce)))
        else $error("New-sample flag not held after its event");

    a_irq_level_match: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        irq == |(status & mask))
        else $error("Interrupt level disagrees with masked status");

endmodule : pstr_event_flags

`default_nettype wire

// file: hdl/pstr_regs_top.sv
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "pstr_regs.svh"

// Summary of operation
// - Fresh sample loads register, sets new-sample flag
// - Each control-limit result loads the DC level
// - Sensitivity stays within 1 to 255
// - Debounce timeout stays within 1 to 255
// - Engine values read-only; tuning values read-write

module pstr_regs_top (
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    input  wire logic                    ce,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`PSTR_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire pstr_pkg::pstr_engine_t  eng,
    output logic      [7:0]              ext_sense,
    output logic      [7:0]              ext_timeout,
    output logic                         irq
);

    pstr_pkg::pstr_regs_st_t st_ff;
    pstr_pkg::pstr_regs_st_t nxt_st;

    logic [`PSTR_NEV-1:0] ev_status;
    logic [`PSTR_NEV-1:0] ev_mask;
    logic [`PSTR_NEV-1:0] set_ev;
    logic [`PSTR_NEV-1:0] clr_ev;
    logic                 mask_wr;
    logic                 range_err;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit_idx(
        input logic [`PSTR_ADDR_W-1:0] addr,
        input logic [`PSTR_IDX_W-1:0]  idx
    );
        hit_idx = (addr[`PSTR_ADDR_W-1:`PSTR_IDX_LSB] == idx);
    endfunction : hit_idx

    // A zero written to a lane that is enabled is out of range
    function automatic logic tune_bad(
        input logic [31:0] wdata,
        input logic [3:0]  strb
    );
        logic s_bad;
        logic d_bad;
        s_bad = strb[`PSTR_SENS_LANE] &&
                (wdata[`PSTR_SENS_F] == `PSTR_TUNE_ZERO);
        d_bad = strb[`PSTR_DBNC_LANE] &&
                (wdata[`PSTR_DBNC_F] == `PSTR_TUNE_ZERO);
        tune_bad = s_bad || d_bad;
    endfunction : tune_bad

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st    = st_ff;
        clr_ev    = `PSTR_EV_RST;
        mask_wr   = 1'b0;
        range_err = 1'b0;

        // Engine updates land whole, never one byte at a time
        if (eng.sample_vld) begin
            nxt_st.sample = eng.sample_data;
        end
        if (eng.dc_vld) begin
            nxt_st.dc = eng.dc_data;
        end

        case (st_ff.phase)
            pstr_pkg::PSTR_IDLE: begin
                if (psel && penable) begin
                    nxt_st.phase   = pstr_pkg::PSTR_ACK;
                    nxt_st.prdata  = `PSTR_DATA_RST;
                    nxt_st.pslverr = 1'b0;
                    nxt_st.rd_clr  = `PSTR_EV_RST;
                    if (hit_idx(paddr, `PSTR_IDX_SAMPLE)) begin
                        // Whole value in one word, so one read is atomic
                        nxt_st.prdata[`PSTR_WORD_F] = st_ff.sample;
                        nxt_st.pslverr      = pwrite;
                    end else if (hit_idx(paddr, `PSTR_IDX_DC)) begin
                        nxt_st.prdata[`PSTR_WORD_F] = st_ff.dc;
                        nxt_st.pslverr      = pwrite;
                    end else if (hit_idx(paddr, `PSTR_IDX_TUNE)) begin
                        nxt_st.prdata[`PSTR_SENS_F] = st_ff.sens;
                        nxt_st.prdata[`PSTR_DBNC_F] = st_ff.dbnc;
                        nxt_st.pslverr      = pwrite &&
                                              tune_bad(pwdata, pstrb);
                    end else if (hit_idx(paddr, `PSTR_IDX_STATUS)) begin
                        nxt_st.prdata[`PSTR_NEV-1:0] = ev_status;
                        // Clear only what this read reports
                        nxt_st.rd_clr  = pwrite ? `PSTR_EV_RST : ev_status;
                        nxt_st.pslverr = pwrite;
                    end else if (hit_idx(paddr, `PSTR_IDX_MASK)) begin
                        nxt_st.prdata[`PSTR_NEV-1:0] = ev_mask;
                    end else begin
                        nxt_st.pslverr = 1'b1;
                    end
                end
            end
            pstr_pkg::PSTR_ACK: begin
                // Completion edge: writes and read side effects act here
                nxt_st.phase  = pstr_pkg::PSTR_IDLE;
                nxt_st.rd_clr = `PSTR_EV_RST;
                clr_ev        = st_ff.rd_clr;
                if (pwrite && hit_idx(paddr, `PSTR_IDX_TUNE)) begin
                    if (st_ff.pslverr) begin
                        range_err = 1'b1;
                    end else begin
                        if (pstrb[`PSTR_SENS_LANE]) begin
                            nxt_st.sens = pwdata[`PSTR_SENS_F];
                        end
                        if (pstrb[`PSTR_DBNC_LANE]) begin
                            nxt_st.dbnc = pwdata[`PSTR_DBNC_F];
                        end
                    end
                end
                if (pwrite && hit_idx(paddr, `PSTR_IDX_MASK)) begin
                    mask_wr = pstrb[`PSTR_MASK_LANE];
                end
            end
            default: begin
                nxt_st.phase = pstr_pkg::PSTR_IDLE;
            end
        endcase
    end

    always_comb begin
        set_ev                 = `PSTR_EV_RST;
        set_ev[`PSTR_EV_SAMPLE] = eng.sample_vld;
        set_ev[`PSTR_EV_DC]     = eng.dc_vld;
        set_ev[`PSTR_EV_RANGE]  = range_err;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{phase:   pstr_pkg::PSTR_IDLE,
                       sample:  `PSTR_WORD_RST,
                       dc:      `PSTR_WORD_RST,
                       sens:    `PSTR_SENS_RST,
                       dbnc:    `PSTR_DBNC_RST,
                       prdata:  `PSTR_DATA_RST,
                       pslverr: 1'b0,
                       rd_clr:  `PSTR_EV_RST};
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Event flags and interrupt
    // ------------------------------------------------------------
    pstr_event_flags u_flags (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .ce         (ce),
        .set_ev     (set_ev),
        .clr_ev     (clr_ev),
        .mask_wr    (mask_wr),
        .mask_wdata (pwdata[`PSTR_NEV-1:0]),
        .status     (ev_status),
        .mask       (ev_mask),
        .irq        (irq)
    );

    assign prdata      = st_ff.prdata;
    assign pready      = st_ff.phase[`PSTR_PH_ACK_BIT];
    assign pslverr     = st_ff.pslverr;
    assign ext_sense   = st_ff.sens;
    assign ext_timeout = st_ff.dbnc;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sample_load: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && eng.sample_vld |=> st_ff.sample == $past(eng.sample_data))
        else $error("Sample not loaded after engine strobe");

    a_dc_level_load: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && eng.dc_vld |=> st_ff.dc == $past(eng.dc_data))
        else $error("DC level not loaded after engine strobe");

    a_sens_in_range: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ext_sense != `PSTR_TUNE_ZERO)
        else $error("Sensitivity left its valid range");

    a_dbnc_in_range: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ext_timeout != `PSTR_TUNE_ZERO)
        else $error("Debounce timeout left its valid range");

    a_ro_pair_hold: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !(ce && eng.sample_vld) && !(ce && eng.dc_vld) |=>
        $stable(st_ff.sample) && $stable(st_ff.dc))
        else $error("Read-only pair changed without engine strobe");

    a_tune_write_ok: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && pready && pwrite && !pslverr && pstrb[`PSTR_SENS_LANE] &&
        hit_idx(paddr, `PSTR_IDX_TUNE) |=> ext_sense == $past(pwdata[7:0]))
        else $error("Sensitivity write not stored");

    a_pair_together: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        $changed(st_ff.sample[7:0]) || $changed(st_ff.sample[15:8]) |->
        st_ff.sample == $past(eng.sample_data) && $past(eng.sample_vld))
        else $error("Sample halves changed apart");

    a_apb_answer: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && psel && penable && !pready |=> pready ##1 !pready)
        else $error("APB answer not exactly one cycle later");

    // ------------------------------------------------------------
    // Bus, flag and freeze checks
    // ------------------------------------------------------------
    // Answer stands one cycle only, so a held request is not taken twice
    a_pready_pulse: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && pready |=> !pready)
        else $error("Bus answer stood longer than one cycle");

    a_phase_onehot: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        $onehot(st_ff.phase))
        else $error("Bus phase register lost its one-hot code");

    a_sample_read: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && psel && penable && !pready && !pwrite && hit_idx(paddr, `PSTR_IDX_SAMPLE) |=>
        prdata == {16'h0000, $past(st_ff.sample)})
        else $error("Sample read did not return one whole word");

    a_ro_write_err: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && psel && penable && !pready && pwrite &&
        (hit_idx(paddr, `PSTR_IDX_SAMPLE) || hit_idx(paddr, `PSTR_IDX_DC)) |=> pslverr)
        else $error("Write to an engine value not refused");

    a_sens_zero_err: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && psel && penable && !pready && pwrite && hit_idx(paddr, `PSTR_IDX_TUNE) &&
        pstrb[`PSTR_SENS_LANE] && pwdata[`PSTR_SENS_F] == `PSTR_TUNE_ZERO |=> pslverr)
        else $error("Zero sensitivity write not refused");

    a_dbnc_zero_err: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && psel && penable && !pready && pwrite && hit_idx(paddr, `PSTR_IDX_TUNE) &&
        pstrb[`PSTR_DBNC_LANE] && pwdata[`PSTR_DBNC_F] == `PSTR_TUNE_ZERO |=> pslverr)
        else $error("Zero debounce timeout write not refused");

    a_tune_refused: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && pready && pwrite && pslverr && hit_idx(paddr, `PSTR_IDX_TUNE) |=>
        $stable(ext_sense) && $stable(ext_timeout) && ev_status[`PSTR_EV_RANGE])
        else $error("Refused tuning write stored data or raised no flag");

    a_dbnc_write_ok: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && pready && pwrite && !pslverr && pstrb[`PSTR_DBNC_LANE] &&
        hit_idx(paddr, `PSTR_IDX_TUNE) |=> ext_timeout == $past(pwdata[`PSTR_DBNC_F]))
        else $error("Debounce timeout write not stored");

    a_status_rd_clear: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && pready && !pwrite && hit_idx(paddr, `PSTR_IDX_STATUS) |=>
        (ev_status & $past(st_ff.rd_clr) & ~$past(set_ev)) == `PSTR_EV_RST)
        else $error("Reported status bits not cleared by their read");

    a_mask_write: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && pready && pwrite && pstrb[`PSTR_MASK_LANE] && hit_idx(paddr, `PSTR_IDX_MASK) |=>
        ev_mask == $past(pwdata[`PSTR_NEV-1:0]))
        else $error("Mask write not stored");

    a_unmapped_err: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && psel && penable && !pready &&
        !hit_idx(paddr, `PSTR_IDX_SAMPLE) && !hit_idx(paddr, `PSTR_IDX_DC) &&
        !hit_idx(paddr, `PSTR_IDX_TUNE) && !hit_idx(paddr, `PSTR_IDX_STATUS) &&
        !hit_idx(paddr, `PSTR_IDX_MASK) |=> pslverr && prdata == `PSTR_DATA_RST)
        else $error("Unmapped access not refused");

    a_dc_flag_set: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && eng.dc_vld |=> ev_status[`PSTR_EV_DC])
        else $error("New DC level flag not raised");

    a_sample_flag_set: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ce && eng.sample_vld |=> ev_status[`PSTR_EV_SAMPLE])
        else $error("New sample flag not raised");

    // A low enable must hold every register, the bus answer included
    a_ce_freeze: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !ce |=> $stable(st_ff) && $stable(ev_status) && $stable(ev_mask) && $stable(irq))
        else $error("State moved while clock enable was low");

endmodule : pstr_regs_top

`default_nettype wire

// file: inc/pstr_pkg.sv
`include "pstr_regs.svh"

package pstr_pkg;

    // Engine side: one sample and one DC level, each with its strobe
    typedef struct packed {
        logic        sample_vld;
        logic [15:0] sample_data;
        logic        dc_vld;
        logic [15:0] dc_data;
    } pstr_engine_t;

    typedef enum logic [1:0] {
        PSTR_IDLE = 2'b01,
        PSTR_ACK  = 2'b10
    } pstr_phase_t;

    typedef struct packed {
        pstr_phase_t               phase;
        logic [15:0]               sample;
        logic [15:0]               dc;
        logic [7:0]                sens;
        logic [7:0]                dbnc;
        logic [31:0]               prdata;
        logic                      pslverr;
        logic [`PSTR_NEV-1:0]      rd_clr;
    } pstr_regs_st_t;

    typedef struct packed {
        logic [`PSTR_NEV-1:0]      status;
        logic [`PSTR_NEV-1:0]      mask;
        logic                      irq;
    } pstr_flag_st_t;

endpackage : pstr_pkg

// file: inc/pstr_regs.svh
`ifndef PSTR_REGS_SVH
`define PSTR_REGS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define PSTR_IDX_W          10
`define PSTR_IDX_SAMPLE     10'h0fa
`define PSTR_IDX_DC         10'h0fc
`define PSTR_IDX_TUNE       10'h0fe
`define PSTR_IDX_STATUS     10'h100
`define PSTR_IDX_MASK       10'h101

// ------------------------------------------------------------
// Field layout
// ------------------------------------------------------------
`define PSTR_ADDR_W         12
`define PSTR_IDX_LSB        2
`define PSTR_SENS_LANE      0
`define PSTR_DBNC_LANE      1
`define PSTR_NEV            3
`define PSTR_EV_SAMPLE      0
`define PSTR_EV_DC          1
`define PSTR_EV_RANGE       2
`define PSTR_MASK_LANE      0
`define PSTR_PH_ACK_BIT     1
`define PSTR_SENS_F         7:0
`define PSTR_DBNC_F         15:8
`define PSTR_WORD_F         15:0

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define PSTR_WORD_RST       16'h0000
`define PSTR_SENS_RST       8'h01
`define PSTR_DBNC_RST       8'h01
`define PSTR_TUNE_ZERO      8'h00
`define PSTR_DATA_RST       32'h0000_0000
`define PSTR_EV_RST         3'h0

`endif

// file: test/test_pstr_regs_top.sv
`timescale 1ns/10ps
`default_nettype none

module test_pstr_regs_top;

    logic                   sys_clk = 1'b0;
    logic                   nrst    = 1'b0;
    logic                   ce      = 1'b1;
    logic                   psel    = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite  = 1'b0;
    logic [11:0]            paddr   = 12'h000;
    logic [31:0]            pwdata  = 32'h0000_0000;
    logic [3:0]             pstrb   = 4'h0;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    pstr_pkg::pstr_engine_t eng     = '0;
    logic [7:0]             ext_sense;
    logic [7:0]             ext_timeout;
    logic                   irq;
    int                     n_errors = 0;
    int                     n_checks = 0;

    always #20 sys_clk = ~sys_clk;

    pstr_regs_top dut (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .eng(eng),
        .ext_sense(ext_sense), .ext_timeout(ext_timeout), .irq(irq)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic er);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        // No answer time is assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] v;
        logic        e;
        apb(1'b0, a, 32'h0, 4'h0, v, e);
        chk("prdata", v, exp);
        chk("pslverr", {31'h0, e}, {31'h0, experr});
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic experr);
        logic [31:0] v;
        logic        e;
        apb(1'b1, a, d, s, v, e);
        chk("pslverr", {31'h0, e}, {31'h0, experr});
    endtask : wr

    task automatic engine(input logic sv, input logic [15:0] sd, input logic dv,
                          input logic [15:0] dd);
        @(posedge sys_clk);
        eng <= {sv, sd, dv, dd};
        @(posedge sys_clk);
        eng <= {1'b0, sd, 1'b0, dd};
        @(negedge sys_clk);
    endtask : engine

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(12'h3e8, 32'h0, 1'b0);
        rd(12'h3f0, 32'h0, 1'b0);
        rd(12'h3f8, 32'h0000_0101, 1'b0);
        rd(12'h400, 32'h0, 1'b0);
        rd(12'h404, 32'h0, 1'b0);
        rd(12'h3fc, 32'h0, 1'b1);
    endtask : t_reset

    // Both engine values in one cycle, then two samples one idle cycle apart
    task automatic t_engine;
        engine(1'b1, 16'ha5c3, 1'b1, 16'h5a3c);
        rd(12'h3e8, 32'h0000_a5c3, 1'b0);
        rd(12'h3f0, 32'h0000_5a3c, 1'b0);
        rd(12'h400, 32'h0000_0003, 1'b0);
        rd(12'h400, 32'h0, 1'b0);
        engine(1'b1, 16'h00ff, 1'b0, 16'h0000);
        engine(1'b1, 16'hff00, 1'b0, 16'h0000);
        rd(12'h3e8, 32'h0000_ff00, 1'b0);
        rd(12'h3f0, 32'h0000_5a3c, 1'b0);
        rd(12'h400, 32'h0000_0001, 1'b0);
    endtask : t_engine

    // Engine values refuse software writes
    task automatic t_readonly;
        wr(12'h3e8, 32'h0000_1111, 4'hf, 1'b1);
        wr(12'h3f0, 32'h0000_2222, 4'hf, 1'b1);
        rd(12'h3e8, 32'h0000_ff00, 1'b0);
        rd(12'h3f0, 32'h0000_5a3c, 1'b0);
    endtask : t_readonly

    // Boundaries 1 and 255, lanes apart, zero refused
    task automatic t_tune;
        wr(12'h3f8, 32'h0000_ff01, 4'h3, 1'b0);
        @(negedge sys_clk);
        chk("ext_sense", {24'h0, ext_sense}, 32'h01);
        chk("ext_timeout", {24'h0, ext_timeout}, 32'hff);
        wr(12'h3f8, 32'h0000_00ff, 4'h1, 1'b0);
        rd(12'h3f8, 32'h0000_ffff, 1'b0);
        wr(12'h3f8, 32'h0000_1e00, 4'h3, 1'b1);
        wr(12'h3f8, 32'h0000_0006, 4'h3, 1'b1);
        rd(12'h3f8, 32'h0000_ffff, 1'b0);
        wr(12'h3f8, 32'h0000_0101, 4'h2, 1'b0);
        rd(12'h3f8, 32'h0000_01ff, 1'b0);
        rd(12'h400, 32'h0000_0004, 1'b0);
    endtask : t_tune

    // Unmasked sample raises irq, masked DC event does not
    task automatic t_irq;
        wr(12'h404, 32'h0000_0001, 4'h1, 1'b0);
        rd(12'h404, 32'h0000_0001, 1'b0);
        engine(1'b0, 16'h0000, 1'b1, 16'h0042);
        chk("irq", {31'h0, irq}, 32'h0);
        engine(1'b1, 16'h0777, 1'b0, 16'h0000);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(12'h400, 32'h0000_0003, 1'b0);
        @(negedge sys_clk);
        chk("irq", {31'h0, irq}, 32'h0);
    endtask : t_irq

    // A low clock enable swallows an engine strobe
    task automatic t_freeze;
        @(posedge sys_clk);
        ce <= 1'b0;
        engine(1'b1, 16'h1234, 1'b1, 16'h4321);
        @(posedge sys_clk);
        ce <= 1'b1;
        rd(12'h3e8, 32'h0000_0777, 1'b0);
        rd(12'h3f0, 32'h0000_0042, 1'b0);
        rd(12'h400, 32'h0, 1'b0);
    endtask : t_freeze

    // Reset in mid-run returns every register to its reset value
    task automatic t_midreset;
        engine(1'b1, 16'h1357, 1'b0, 16'h0000);
        chk("irq", {31'h0, irq}, 32'h1);
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        chk("ext_sense", {24'h0, ext_sense}, 32'h01);
        chk("ext_timeout", {24'h0, ext_timeout}, 32'h01);
        chk("irq", {31'h0, irq}, 32'h0);
        t_reset;
    endtask : t_midreset

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic conclude;
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset;
        t_engine;
        t_readonly;
        t_tune;
        t_irq;
        t_freeze;
        t_midreset;
        conclude;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        conclude;
    end

endmodule : test_pstr_regs_top

`default_nettype wire
